// ---- verilog/bbsr_pkg.sv ----
// constants shared by the bus shift register design
// Function
// RULE1: eight stages load parallel from either bus or serially, word shown in parallel
// RULE2: sixteen two-way lines, eight per bus, roles set by transfer direction
// RULE3: each stage is master-slave, moving data with or without a clock edge
// RULE4: parallel select high, async select low: load bus data on tick rise
// RULE5: parallel select high, async select high: load bus data without tick
// RULE6: direction high: port one in, port two out; low reverses both
// RULE7: port one lines enabled only while port one drive enable is high
// RULE8: parallel, direction high, enable low: stages recirculate, port two still driven
// RULE9: the controller holds data by direction high and port one enable low
// RULE10: parallel select low: shift serial input in on each tick rise
// RULE11: serial mode ignores async select; shifting is always synchronous
// RULE12: serial word goes to port two, or port one when direction low, enable high
// RULE13: serial, enable low, direction low: port one stays off while shifting
// RULE14: parallel, direction low, enable low: load from port two, port one undriven
// RULE15: parallel, direction low, enable high: load from port two, drive port one
// RULE16: parallel, direction high, enable high: load from port one, drive port two
// RULE17: first stage takes serial input, others the previous stage, last is visible
// RULE18: no reset pin; contents are unspecified until first load or shift
package bbsr_pkg;
   localparam int          STAGES          = 8;       // register stages per bus
   localparam int          BUF_DEPTH       = 2;       // words held in the word buffer
   localparam int          SYNC_FLOPS      = 3;       // flops on each pin input
   localparam int          CLOCK_PERIOD_NS = 4;       // 250 MHz system clock
   localparam logic [7:0]  STAGE_RESET     = 8'h00;   // contents after system reset
   // field positions in the packed pin vector
   localparam int          PIN_B_LSB       = 0;
   localparam int          PIN_A_LSB       = 8;
   localparam int          PIN_PODE        = 16;
   localparam int          PIN_DIR         = 17;
   localparam int          PIN_ASYNC       = 18;
   localparam int          PIN_LOAD        = 19;
   localparam int          PIN_SER         = 20;
   localparam int          PIN_TICK        = 21;
   localparam int          PIN_W           = 22;
endpackage : bbsr_pkg

// ---- verilog/bbsr_word_if.sv ----
// valid/ready word channel between the register core and its buffer
interface bbsr_word_if #(parameter int W = bbsr_pkg::STAGES);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : bbsr_word_if

// ---- verilog/bbsr_stages.sv ----
// the eight register stages with parallel and serial entry
module bbsr_stages #(
   parameter int N = bbsr_pkg::STAGES
) (
   // clock and system reset
   input  wire logic         clock,
   input  wire logic         rst,
   // load control
   input  wire logic         load_en,
   input  wire logic         par_en,
   input  wire logic [N-1:0] par_data,
   input  wire logic         ser_in,
   // stored word
   output logic      [N-1:0] q
);
   logic [N-1:0] next_q;

   // per stage steering: parallel word or the neighbour below
   for (genvar i = 0; i < N; i++) begin : g_stage
      always_comb begin
         if (!load_en) begin
            next_q[i] = q[i];
         end else if (par_en) begin
            next_q[i] = par_data[i];                  // see RULE3
         end else if (i == 0) begin
            next_q[i] = ser_in;                       // see RULE17
         end else begin
            next_q[i] = q[i-1];                       // see RULE17
         end
      end
   end

   // rst only gives the model a known start, the stages have no reset pin
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= N'(bbsr_pkg::STAGE_RESET);              // see RULE18
      end else begin
         q <= next_q;                                 // see RULE1
      end
   end
endmodule : bbsr_stages

// ---- verilog/bbsr_word_buf.sv ----
// small word buffer with valid and ready on both sides
module bbsr_word_buf #(
   parameter int W     = bbsr_pkg::STAGES,
   parameter int DEPTH = bbsr_pkg::BUF_DEPTH
) (
   // clock and system reset
   input  wire logic         clock,
   input  wire logic         rst,
   // filling side
   bbsr_word_if.snk          in_port,
   // draining side
   output logic      [W-1:0] out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0]   next_count;
   logic          push;
   logic          pop;

   // honest full and empty from the occupancy count
   assign in_port.ready = (count != (AW+1)'(DEPTH));
   assign out_valid     = (count != '0);
   assign out_data      = mem[rd_ptr];
   assign push          = in_port.valid && in_port.ready;
   assign pop           = out_valid && out_ready;

   // pointer and count next values
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // registers; storage needs no reset since count guards it
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_port.data;
      end
   end

   AST_BUF_NO_OVERFLOW: assert property (@(posedge clock) disable iff (rst) // see RULE1
      count <= (AW+1)'(DEPTH)) else $error("word buffer overflow");
endmodule : bbsr_word_buf

// ---- verilog/bbsr_top.sv ----
// bus shift register: pin filtering, mode steering, bus drive and word stream
module bbsr_top #(
   parameter int N = bbsr_pkg::STAGES
) (
   // clock and system reset
   input  wire logic         clock,
   input  wire logic         rst,
   // control pins
   input  wire logic         shift_tick,
   input  wire logic         serial_in,
   input  wire logic         load_sel,
   input  wire logic         async_sel,
   input  wire logic         dir_a_to_b,
   input  wire logic         port_one_drive_enable,
   // port one lines
   input  wire logic [N-1:0] a_in,
   output logic      [N-1:0] a_out,
   output logic              a_oe_n,
   // port two lines
   input  wire logic [N-1:0] b_in,
   output logic      [N-1:0] b_out,
   output logic              b_oe_n,
   // cascade output
   output logic              last_stage,
   // stream of every word the stages take
   output logic      [N-1:0] word_data,
   output logic              word_valid,
   input  wire logic         word_ready
);
   localparam int PW = bbsr_pkg::PIN_W;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   //
   // every pin crosses into the clock here
   // three flops per pin, two must agree
   // a change shows four edges later
   // same latency for data and tick pins
   // a level flipping every cycle is held,
   // so a floating bus loads no noise
   // trade-off: short pulses may be missed
   // keep the tick high and low three clocks
   // flops reset to zero, every pin's idle

   logic [PW-1:0] raw;
   logic [PW-1:0] sync1;
   logic [PW-1:0] sync2;
   logic [PW-1:0] sync3;
   logic [PW-1:0] filt;
   logic [PW-1:0] next_filt;

   // all pins share one vector so their latency matches
   assign raw = {shift_tick, serial_in, load_sel, async_sel,
                 dir_a_to_b, port_one_drive_enable, a_in, b_in};

   // a bit changes only once the second and third flops agree
   always_comb begin
      next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
   end

   // the first flop feeds nothing but the second
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt  <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= next_filt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // filtered pin levels

   logic [N-1:0] a_f;
   logic [N-1:0] b_f;
   logic         pode_f;
   logic         dir_f;
   logic         async_f;
   logic         load_f;
   logic         ser_f;
   logic         tick_f;

   assign b_f     = filt[bbsr_pkg::PIN_B_LSB +: N];
   assign a_f     = filt[bbsr_pkg::PIN_A_LSB +: N];
   assign pode_f  = filt[bbsr_pkg::PIN_PODE];
   assign dir_f   = filt[bbsr_pkg::PIN_DIR];
   assign async_f = filt[bbsr_pkg::PIN_ASYNC];
   assign load_f  = filt[bbsr_pkg::PIN_LOAD];
   assign ser_f   = filt[bbsr_pkg::PIN_SER];
   assign tick_f  = filt[bbsr_pkg::PIN_TICK];

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   //
   // load_sel low: serial, async ignored
   // load_sel high: parallel entry
   // dir high, enable high: from port one
   // dir high, enable low: recirculate
   // dir low: from port two
   // hold a word with dir high, enable low
   // limitation: async load lands five
   // clocks after the bus settles
   // a turnaround shows the old word first

   logic         par_mode;
   logic         async_load;
   logic         from_a;
   logic         recirc;
   logic [N-1:0] q;
   logic [N-1:0] par_word;

   // the async select means nothing in serial mode
   assign par_mode   = load_f;                                    // see RULE10
   assign async_load = par_mode && async_f;                       // see RULE11
   // port one is an input only while its drive enable is high
   assign from_a     = dir_f && pode_f;                           // see RULE7
   // direction high with enable low is the controller's hold setting
   assign recirc     = dir_f && !pode_f;                          // see RULE9

   // source word for a parallel load
   always_comb begin
      if (from_a) begin
         par_word = a_f;                                          // see RULE16
      end else if (recirc) begin
         par_word = q;                                            // see RULE8
      end else begin
         par_word = b_f;                                          // see RULE14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tick edge detection and pending tick
   //
   // only the rising tick edge acts
   // edge flop resets low like the pin,
   // so reset release makes no false edge
   // a full buffer makes a tick pending
   // later ticks in a stall merge into it
   // hazard: merged ticks are lost
   // async mode drops ticks and the pending

   logic tick_d;
   logic tick_rise;
   logic pend;
   logic next_pend;
   logic buf_ready;
   logic fire;
   logic async_upd;
   logic upd;

   assign tick_rise = tick_f && !tick_d;

   // the first tick that meets a full buffer waits rather than being lost
   assign fire      = (tick_rise || pend) && !async_load && buf_ready;  // see RULE4
   // asynchronous transfer follows the bus level, no tick needed
   assign async_upd = async_load && (par_word != q) && buf_ready;      // see RULE5
   assign upd       = fire || async_upd;

   // pending tick next value; a tick in async mode has nothing to do
   always_comb begin
      if (async_load || fire) begin
         next_pend = 1'b0;
      end else begin
         next_pend = pend || tick_rise;
      end
   end

   // tick state registers
   always_ff @(posedge clock) begin
      if (rst) begin
         tick_d <= 1'b0;
         pend   <= 1'b0;
      end else begin
         tick_d <= tick_f;
         pend   <= next_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register stages

   bbsr_stages #(
      .N        (N)
   ) u_stages (
      .clock    (clock),
      .rst      (rst),
      .load_en  (upd),
      .par_en   (par_mode),
      .par_data (par_word),
      .ser_in   (ser_f),
      .q        (q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // word stream through the two-entry buffer

   bbsr_word_if #(.W(N)) word_ch ();

   // every word taken by the stages is offered; a stall holds the stages
   assign word_ch.data  = par_mode ? par_word : {q[N-2:0], ser_f};
   assign word_ch.valid = upd;
   assign buf_ready     = word_ch.ready;

   bbsr_word_buf #(
      .W         (N),
      .DEPTH     (bbsr_pkg::BUF_DEPTH)
   ) u_buf (
      .clock     (clock),
      .rst       (rst),
      .in_port   (word_ch.snk),
      .out_data  (word_data),
      .out_valid (word_valid),
      .out_ready (word_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus drive
   //
   // drive values ignore the enables
   // only the enables move with the pins
   // pads merge value and low enable
   // enables follow filtered pins directly,
   // so a bus turns four edges after its pins
   // no bus is driven after reset
   // last_stage shares the stage flops

   // both buses carry the stored word straight from the stage flops
   assign a_out      = q;                                         // see RULE2
   assign b_out      = q;                                         // see RULE2
   assign last_stage = q[N-1];                                    // see RULE17

   // port one drives only with direction low and its enable high
   assign a_oe_n = !(!dir_f && pode_f);                           // see RULE15
   // port two drives whenever direction is high, also in recirculation
   assign b_oe_n = !dir_f;                                        // see RULE6

   ////////////////////////////////////////////////////////////////////////////
   // checks
   //
   // checks watch the filtered pins
   // that the steering logic used
   // stage checks look one edge ahead,
   // since the stages update one edge late
   // buffer checks live in the buffer

   AST_SYNC_LOAD_A: assert property (@(posedge clock) disable iff (rst) // see RULE16
      (fire && par_mode && from_a) |=> (q == $past(a_f)))
      else $error("sync load from port one missed");

   AST_LOAD_B: assert property (@(posedge clock) disable iff (rst)      // see RULE14
      (upd && par_mode && !dir_f) |=> (q == $past(b_f)))
      else $error("load from port two missed");

   AST_RECIRC_HOLD: assert property (@(posedge clock) disable iff (rst) // see RULE8
      (par_mode && recirc && $stable(filt)) |=> $stable(q))
      else $error("recirculation changed the word");

   AST_SHIFT: assert property (@(posedge clock) disable iff (rst)       // see RULE10
      (fire && !par_mode) |=> (q == {$past(q[N-2:0]), $past(ser_f)}))
      else $error("serial shift wrong");

   AST_NO_ASYNC_SHIFT: assert property (@(posedge clock) disable iff (rst) // see RULE11
      (!par_mode && !tick_rise && !pend) |=> $stable(q))
      else $error("serial word moved without a tick");

   AST_SYNC_WAITS: assert property (@(posedge clock) disable iff (rst)  // see RULE4
      (par_mode && !async_f && !tick_rise && !pend) |=> $stable(q))
      else $error("sync load without a tick");

   AST_ASYNC_FOLLOW: assert property (@(posedge clock) disable iff (rst) // see RULE5
      (async_load && buf_ready && !recirc) |=> (q == $past(par_word)))
      else $error("async load did not follow the bus");

   AST_A_DRIVE: assert property (@(posedge clock) disable iff (rst)     // see RULE7
      !a_oe_n |-> (pode_f && !dir_f))
      else $error("port one driven while disabled");

   AST_A_OFF_SERIAL: assert property (@(posedge clock) disable iff (rst) // see RULE13
      (!par_mode && !pode_f && !dir_f) |-> a_oe_n)
      else $error("port one driven in serial mode with enable low");

   AST_DIR_ROLES: assert property (@(posedge clock) disable iff (rst)   // see RULE12
      dir_f |-> (!b_oe_n && a_oe_n))
      else $error("bus roles wrong for direction high");

   AST_TICK_LATENCY: assert property (@(posedge clock) disable iff (rst) // see RULE17
      (tick_rise && !par_mode && buf_ready) |=> (q[0] == $past(ser_f)))
      else $error("first stage did not take serial input");

   AST_B_OFF_DIR_LOW: assert property (@(posedge clock) disable iff (rst) // see RULE6
      !dir_f |-> b_oe_n)
      else $error("port two driven with direction low");

   AST_A_SERIAL_DRIVE: assert property (@(posedge clock) disable iff (rst) // see RULE12
      (!par_mode && !dir_f && pode_f) |-> !a_oe_n)
      else $error("port one not driven for serial output");

   AST_B_RECIRC_DRIVE: assert property (@(posedge clock) disable iff (rst) // see RULE8
      recirc |-> !b_oe_n)
      else $error("port two released in recirculation");

   AST_A_OFF_PAR_LOW: assert property (@(posedge clock) disable iff (rst) // see RULE14
      (par_mode && !pode_f) |-> a_oe_n)
      else $error("port one driven with enable low");

   AST_SERIAL_NOT_ASYNC: assert property (@(posedge clock) disable iff (rst) // see RULE11
      !par_mode |-> !async_load)
      else $error("async load in serial mode");

   AST_STALL_HOLDS: assert property (@(posedge clock) disable iff (rst) // see RULE1
      !buf_ready |=> $stable(q))
      else $error("stages moved with the buffer full");

   AST_TICK_KEPT: assert property (@(posedge clock) disable iff (rst) // see RULE10
      (tick_rise && !async_load && !buf_ready) |=> pend)
      else $error("tick lost with the buffer full");

   AST_WORD_OFFERED: assert property (@(posedge clock) disable iff (rst) // see RULE1
      upd |=> word_valid)
      else $error("taken word not offered");

   AST_ASYNC_DROPS_TICK: assert property (@(posedge clock) disable iff (rst) // see RULE5
      async_load |=> !pend)
      else $error("tick kept in async mode");

   AST_SER_B_OFF: assert property (@(posedge clock) disable iff (rst) // see RULE13
      (!par_mode && !dir_f && !pode_f) |-> b_oe_n)
      else $error("port two driven in serial mode");

   AST_ASYNC_SAME_HOLDS: assert property (@(posedge clock) disable iff (rst) // see RULE5
      (async_load && (par_word == q)) |=> $stable(q))
      else $error("async load changed an equal word");

   AST_LAST_FOLLOWS: assert property (@(posedge clock) disable iff (rst) // see RULE17
      (fire && !par_mode) |=> (last_stage == $past(q[N-2])))
      else $error("cascade output did not follow");
endmodule : bbsr_top

// ---- verif/bbsr_far_bus.sv ----
// far-side bus logic: drives both parallel buses and drains the word stream
module bbsr_far_bus (
   // clock
   input  wire logic        clock,
   // what the testbench wants on the buses
   input  wire logic [7:0]  a_val,
   input  wire logic        a_en,
   input  wire logic [7:0]  b_val,
   input  wire logic        b_en,
   input  wire logic        stall,
   // device side of the buses
   input  wire logic [7:0]  a_out,
   input  wire logic        a_oe_n,
   input  wire logic [7:0]  b_out,
   input  wire logic        b_oe_n,
   output logic      [7:0]  a_in,
   output logic      [7:0]  b_in,
   // word stream sink
   input  wire logic [7:0]  word_data,
   input  wire logic        word_valid,
   output logic             word_ready,
   output logic      [7:0]  last_word,
   output logic      [15:0] pop_count
);
   logic       toggle = 1'b0;
   logic [7:0] float_val;

   ////////////////////////////////////////////////////////////////////////////////////////
   // a bus nobody drives must not look stable, so it flips every cycle
   assign float_val = 8'h55 ^ {8{toggle}};
   assign a_in = !a_oe_n ? a_out : (a_en ? a_val : float_val);
   assign b_in = !b_oe_n ? b_out : (b_en ? b_val : float_val);
   assign word_ready = !stall;

   // take each word the device offers while not stalled
   initial begin
      last_word = 8'h00;
      pop_count = 16'h0000;
   end
   always @(posedge clock) begin
      toggle <= ~toggle;
      if (word_valid && word_ready) begin
         last_word <= word_data;
         pop_count <= pop_count + 16'h0001;
      end
   end
endmodule : bbsr_far_bus

// ---- verif/test_bidir_bus_shift_register.sv ----
// self-checking testbench for the bus shift register
module test_bidir_bus_shift_register;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, rst, shift_tick, serial_in, load_sel, async_sel;
   logic        dir_a_to_b, port_one_drive_enable, a_oe_n, b_oe_n, last_stage;
   logic        word_valid, word_ready, a_en, b_en, stall;
   logic [7:0]  a_in, a_out, b_in, b_out, word_data, a_val, b_val, last_word;
   logic [15:0] pop_count;
   int          n_errors = 0;
   int          check_count = 0;

   ////////////////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial clock = 1'b0;
   always #2 clock = ~clock;

   bbsr_top dut_u (.clock(clock), .rst(rst), .shift_tick(shift_tick), .serial_in(serial_in),
      .load_sel(load_sel), .async_sel(async_sel), .dir_a_to_b(dir_a_to_b),
      .port_one_drive_enable(port_one_drive_enable), .a_in(a_in), .a_out(a_out),
      .a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n),
      .last_stage(last_stage), .word_data(word_data), .word_valid(word_valid),
      .word_ready(word_ready));

   bbsr_far_bus far_u (.clock(clock), .a_val(a_val), .a_en(a_en), .b_val(b_val),
      .b_en(b_en), .stall(stall), .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
      .b_oe_n(b_oe_n), .a_in(a_in), .b_in(b_in), .word_data(word_data),
      .word_valid(word_valid), .word_ready(word_ready), .last_word(last_word),
      .pop_count(pop_count));

   ////////////////////////////////////////////////////////////////////////////////////////
   // pins move 1 ns after an edge, never on it
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   // tick held 4 clocks each way, longer than the 3-clock pin filter needs
   task automatic shift_bit(input logic b);
      serial_in = b;
      step(1);
      shift_tick = 1'b1;
      step(4);
      shift_tick = 1'b0;
      step(4);
   endtask : shift_bit

   // mode pins, then clocks for the filter, a bus turnaround and an async follow
   task automatic set_mode(input logic ld, input logic asy, input logic dir, input logic pe);
      load_sel = ld;
      async_sel = asy;
      dir_a_to_b = dir;
      port_one_drive_enable = pe;
      step(10);
   endtask : set_mode

   task automatic check_word(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_flag(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // bounded wait for the sink to have taken a given number of words
   task automatic wait_pop(input logic [15:0] target);
      int k;
      k = 0;
      while (pop_count !== target && k < 40) begin
         step(1);
         k++;
      end
      // a timeout counts as a mismatch; the run still ends in the verdict
      if (pop_count !== target) begin
         n_errors++;
         $display("CHECK FAILED pop_count expected %0d seen %0d", target, pop_count);
      end
   endtask : wait_pop

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [15:0] pc;
      logic [7:0]  exp_q [3];
      {rst, shift_tick, serial_in, load_sel, async_sel} = 5'b10000;
      {dir_a_to_b, port_one_drive_enable, a_en, b_en, stall} = 5'b00000;
      a_val = 8'h00;
      b_val = 8'h00;
      step(5);
      rst = 1'b0;
      // serial fill, msb first; async select set but must be ignored
      set_mode(1'b0, 1'b1, 1'b1, 1'b0);
      check_flag("b_oe_n", 1'b0, b_oe_n);
      check_flag("a_oe_n", 1'b1, a_oe_n);
      for (int i = 7; i >= 0; i--) shift_bit(1'(8'ha5 >> i));
      check_word("b_out", 8'ha5, b_out);
      check_flag("last_stage", 1'b1, last_stage);
      check_word("word", 8'ha5, last_word);
      serial_in = 1'b1;
      step(10);
      check_word("b_out", 8'ha5, b_out);
      shift_bit(1'b0);
      check_word("b_out", 8'h4a, b_out);
      check_flag("last_stage", 1'b0, last_stage);
      $display("test serial shift done");
      // serial word steered to port one, then port one switched off
      set_mode(1'b0, 1'b0, 1'b0, 1'b1);
      check_flag("a_oe_n", 1'b0, a_oe_n);
      check_word("a_out", 8'h4a, a_out);
      check_flag("b_oe_n", 1'b1, b_oe_n);
      set_mode(1'b0, 1'b0, 1'b0, 1'b0);
      check_flag("a_oe_n", 1'b1, a_oe_n);
      shift_bit(1'b1);
      check_word("word", 8'h95, last_word);
      $display("test serial steering done");
      // synchronous load from port one
      a_val = 8'h3c;
      a_en = 1'b1;
      set_mode(1'b1, 1'b0, 1'b1, 1'b1);
      check_flag("a_oe_n", 1'b1, a_oe_n);
      check_word("b_out", 8'h95, b_out);
      shift_bit(1'b0);
      check_word("b_out", 8'h3c, b_out);
      $display("test load port one done");
      // asynchronous and synchronous loads from port two
      a_en = 1'b0;
      b_val = 8'hc3;
      b_en = 1'b1;
      set_mode(1'b1, 1'b1, 1'b0, 1'b1);
      check_flag("a_oe_n", 1'b0, a_oe_n);
      check_word("a_out", 8'hc3, a_out);
      b_val = 8'h5a;
      step(7);
      check_word("a_out", 8'h5a, a_out);
      set_mode(1'b1, 1'b1, 1'b0, 1'b0);
      check_flag("a_oe_n", 1'b1, a_oe_n);
      b_val = 8'he7;
      step(7);
      check_word("word", 8'he7, last_word);
      set_mode(1'b1, 1'b0, 1'b0, 1'b1);
      b_val = 8'h81;
      step(7);
      check_word("a_out", 8'he7, a_out);
      shift_bit(1'b0);
      check_word("a_out", 8'h81, a_out);
      $display("test load port two done");
      // hold by recirculation while port one carries other data
      set_mode(1'b1, 1'b0, 1'b1, 1'b0);
      b_en = 1'b0;
      a_val = 8'hff;
      a_en = 1'b1;
      pc = pop_count;
      shift_bit(1'b0);
      check_word("b_out", 8'h81, b_out);
      check_flag("b_oe_n", 1'b0, b_oe_n);
      check_word("pops", pc[7:0] + 8'h01, pop_count[7:0]);
      set_mode(1'b1, 1'b1, 1'b1, 1'b0);
      a_val = 8'h00;
      step(7);
      check_word("b_out", 8'h81, b_out);
      $display("test recirculation done");
      // three shifts while the sink stalls: no word may be lost
      stall = 1'b1;
      set_mode(1'b0, 1'b0, 1'b1, 1'b0);
      pc = pop_count;
      exp_q = '{8'h03, 8'h07, 8'h0f};
      for (int i = 0; i < 3; i++) shift_bit(1'b1);
      check_flag("word_valid", 1'b1, word_valid);
      check_word("word", 8'h81, last_word);
      stall = 1'b0;
      for (int i = 0; i < 3; i++) begin
         wait_pop(pc + 16'(i + 1));
         check_word("word", exp_q[i], last_word);
      end
      check_word("b_out", 8'h0f, b_out);
      $display("test stalled stream done");
      print_verdict();
   end
endmodule : test_bidir_bus_shift_register
